//--- dscl_pkg.sv
// package: shared constants for the serial converter command loader
package dscl_pkg;
    localparam int          WORD_BITS   = 16;
    localparam int          CODE_BITS   = 12;
    localparam int          CNT_W       = 5;
    // word layout, msb first
    localparam int          CMD2_POS    = 15;
    localparam int          CMD1_POS    = 14;
    localparam int          CMD0_POS    = 13;
    localparam int          CODE_MSB    = 12;
    localparam int          CODE_LSB    = 1;
    localparam int          SUB_POS     = 0;
    localparam logic [11:0] CODE_RESET  = 12'h000;
    localparam logic [11:0] CODE_MID    = 12'h800;
    // timing: host shift clock half period and select guard times
    localparam int          CLK_MHZ     = 200;
    localparam int          SCLK_MAX_MHZ = 10;
    localparam int          HALF_NS     = 50;
    localparam int          GUARD_NS    = 100;
    localparam int          HALF_CYC    = (HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int          GUARD_CYC   = (GUARD_NS * CLK_MHZ + 999) / 1000;
    localparam int          TIM_W       = 8;
    // apb register map of the host controller
    localparam logic [7:0]  REG_DATA    = 8'h00;
    localparam logic [7:0]  REG_CTRL    = 8'h04;
    localparam logic [7:0]  REG_STAT    = 8'h08;
    localparam int          CTRL_GO     = 0;
    localparam int          STAT_BUSY   = 0;
endpackage

//--- dscl_if.sv
// interface: three-wire serial link between host and converter
`timescale 1ns/10ps
interface dscl_if;
    logic select_n;
    logic shift_clock;
    logic serial_in;
    modport host (output select_n, output shift_clock, output serial_in);
    modport dev  (input select_n, input shift_clock, input serial_in);
endinterface

//--- dscl_sync.sv
// module: two flip-flop synchroniser for link pins
`timescale 1ns/10ps
module dscl_sync
    import dscl_pkg::*;
#(
    parameter int W = 3
) (
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_q;
    // first stage feeds only the second stage
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            meta_q <= '1;
            q_out  <= '1;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule

//--- dscl_dev.sv
// module: converter end, shifts words in and applies commands
`timescale 1ns/10ps
module dscl_dev
    import dscl_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 nrst_in,
    dscl_if.dev                       link,
    output logic [CODE_BITS-1:0]      input_code_out,
    output logic [CODE_BITS-1:0]      conv_code_out,
    output logic                      shutdown_out,
    output logic                      update_out
);
    // ------------------------------------------------------------
    // pin sampling and edge detection
    // ------------------------------------------------------------
    logic [2:0]           pins_s;
    logic                 sel_n_s, sck_s, din_s;
    logic                 sck_prev_q, sel_prev_q;
    logic                 sck_rise, sel_rise;
    logic [WORD_BITS-1:0] shift_q;

    dscl_sync #(.W(3)) u_sync (
        .clk_in  (clk_in),
        .nrst_in (nrst_in),
        .d_in    ({link.select_n, link.shift_clock, link.serial_in}),
        .q_out   (pins_s)
    );
    assign {sel_n_s, sck_s, din_s} = pins_s;

    // previous levels for edge finding
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            sck_prev_q <= 1'b1;   // same as synchroniser reset level: no false rise
            sel_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            sel_prev_q <= sel_n_s;
        end
    end
    assign sck_rise = sck_s && !sck_prev_q && !sel_n_s;
    assign sel_rise = sel_n_s && !sel_prev_q;

    // ------------------------------------------------------------
    // shift register, msb first
    // ------------------------------------------------------------
    // keeps shifting during shutdown so the link stays usable
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            shift_q <= '0;
        end else if (sck_rise) begin
            shift_q <= {shift_q[WORD_BITS-2:0], din_s};
        end
    end

    // ------------------------------------------------------------
    // command decode on select rise
    // ------------------------------------------------------------
    logic c2, c1, c0;
    logic [CODE_BITS-1:0] code;
    // only the last sixteen bits count; short words give stale bits
    assign c2   = shift_q[CMD2_POS];
    assign c1   = shift_q[CMD1_POS];
    assign c0   = shift_q[CMD0_POS];
    assign code = shift_q[CODE_MSB:CODE_LSB];             // sub_bit unused

    // input register
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            input_code_out <= CODE_RESET;
        end else if (sel_rise && !c1) begin
            input_code_out <= code;
        end
    end

    // converter register, straight binary code to the ladder
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            conv_code_out <= CODE_RESET;
        end else if (sel_rise && !c1 && !c0) begin
            conv_code_out <= code;
        end else if (sel_rise && c1 && !c0) begin
            conv_code_out <= input_code_out;
        end
    end

    // shutdown state; input register survives it
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            shutdown_out <= 1'b0;
        end else if (sel_rise && !c0) begin
            shutdown_out <= 1'b0;
        end else if (sel_rise && c1 && c0 && c2) begin
            shutdown_out <= 1'b1;
        end
    end

    // one-cycle pulse when a word is acted on (not for no_operation)
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            update_out <= 1'b0;
        end else begin
            update_out <= sel_rise && !(c1 && c0 && !c2);
        end
    end
endmodule

//--- dscl_host.sv
// module: host end, apb slave that serialises command words
`timescale 1ns/10ps
module dscl_host
    import dscl_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    dscl_if.host             link
);
    typedef enum logic [1:0] {IDLE, SETUP, SHIFT, HOLD} dscl_st_e;
    dscl_st_e             st_q;
    logic [WORD_BITS-1:0] word_q, tx_q;
    logic [CNT_W-1:0]     bits_q;
    logic [TIM_W-1:0]     tim_q;
    logic                 acc, go;

    // ------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------
    assign acc = psel_in && penable_in;
    // start only when idle and the select high gap has run out; a go while busy is dropped
    assign go  = acc && pwrite_in && paddr_in == REG_CTRL && pwdata_in[CTRL_GO]
                 && st_q == IDLE && tim_q == '0;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            word_q <= '0;
        end else if (acc && pwrite_in && paddr_in == REG_DATA) begin
            word_q <= pwdata_in[WORD_BITS-1:0];
        end
    end

    // read mux and answer, registered for flop outputs
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            prdata_out  <= '0;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && paddr_in != REG_DATA
                           && paddr_in != REG_CTRL && paddr_in != REG_STAT;
            prdata_out  <= '0;
            if (psel_in && !penable_in && !pwrite_in) begin
                if (paddr_in == REG_DATA)
                    prdata_out <= {16'h0000, word_q};
                else if (paddr_in == REG_STAT)
                    prdata_out <= {31'h0000_0000, (st_q != IDLE) || (tim_q != '0)};
            end
        end
    end

    // ------------------------------------------------------------
    // serialiser: shift clock of about 9.09 MHz (110 ns period) from 200 MHz clock
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st_q             <= IDLE;
            tx_q             <= '0;
            bits_q           <= '0;
            tim_q            <= '0;
            link.select_n    <= 1'b1;
            link.shift_clock <= 1'b0;
            link.serial_in   <= 1'b0;
        end else begin
            case (st_q)
                IDLE: begin
                    if (go) begin
                        // sub_bit forced low
                        tx_q             <= {word_q[WORD_BITS-1:1], 1'b0};
                        link.select_n    <= 1'b0;
                        link.serial_in   <= word_q[WORD_BITS-1];
                        tim_q            <= TIM_W'(GUARD_CYC);
                        bits_q           <= '0;
                        st_q             <= SETUP;
                    end else if (tim_q != '0) begin
                        // select stays high for the gap before another word
                        tim_q <= tim_q - 1'b1;
                    end
                end
                SETUP: begin
                    if (tim_q == 0) begin
                        link.shift_clock <= 1'b1;
                        tim_q            <= TIM_W'(HALF_CYC);
                        st_q             <= SHIFT;
                    end else begin
                        tim_q <= tim_q - 1'b1;
                    end
                end
                SHIFT: begin
                    // half period of 55 ns (HALF_CYC plus one cycle) gives a clock of about 9.09 MHz
                    if (tim_q != 0) begin
                        tim_q <= tim_q - 1'b1;
                    end else if (link.shift_clock) begin
                        link.shift_clock <= 1'b0;
                        tx_q             <= {tx_q[WORD_BITS-2:0], 1'b0};
                        link.serial_in   <= tx_q[WORD_BITS-2];
                        bits_q           <= bits_q + 1'b1;
                        tim_q            <= TIM_W'(HALF_CYC);
                        if (bits_q == CNT_W'(WORD_BITS - 1)) begin
                            st_q  <= HOLD;
                            tim_q <= TIM_W'(GUARD_CYC);
                        end
                    end else begin
                        link.shift_clock <= 1'b1;
                        tim_q            <= TIM_W'(HALF_CYC);
                    end
                end
                HOLD: begin
                    // select stays low for all sixteen bits, then rises
                    if (tim_q == 0) begin
                        link.select_n <= 1'b1;
                        tim_q         <= TIM_W'(GUARD_CYC);
                        st_q          <= IDLE;
                    end else begin
                        tim_q <= tim_q - 1'b1;
                    end
                end
                default: st_q <= IDLE;
            endcase
        end
    end
endmodule

//--- dscl_link_properties.sv
// checker: wire-level properties of the serial command link
`timescale 1ns/10ps
module dscl_link_chk (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic select_n,
    input  wire logic shift_clock,
    input  wire logic serial_in
);
    logic       sclk_q;
    logic [4:0] bits_q;
    // -------------------------------------------------------------
    // helper: shift clock history and bit count within a frame
    // -------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        sclk_q <= shift_clock;
    end
    // count cleared while deselected so a new frame starts at zero
    always_ff @(posedge clk_in) begin
        if (!nrst_in || select_n) begin
            bits_q <= 5'h00;
        end else if (shift_clock && !sclk_q) begin
            bits_q <= bits_q + 5'h01;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // select held high for the full 100 ns gap between words
    sequence s_high_gap;
        select_n[*8] ##1 select_n[*8] ##1 select_n[*4];
    endsequence
    sequence s_low_hold;
        !shift_clock[*8];
    endsequence
    a_idle_clock_low: assert property (select_n |-> !shift_clock) else $error("clock moves while deselected");
    a_setup_before: assert property ($fell(select_n) |-> s_low_hold) else $error("clock rise too soon");
    a_clock_high: assert property ($rose(shift_clock) |-> shift_clock[*8]) else $error("clock high too short");
    a_clock_low: assert property ($fell(shift_clock) |-> s_low_hold) else $error("clock low too short");
    a_sixteen_bits: assert property ($rose(select_n) |-> bits_q == 5'h10) else $error("word not 16 bits");
    a_sub_zero: assert property (bits_q == 5'h0F && shift_clock && !sclk_q |-> !serial_in)
        else $error("sub bit not zero");
    a_data_stable: assert property (shift_clock && sclk_q |-> $stable(serial_in)) else $error("data moved");
    a_word_gap: assert property ($rose(select_n) |-> s_high_gap) else $error("select gap too short");
    a_frame_ends: assert property ($fell(select_n) |-> ##[1:1000] select_n) else $error("frame never ends");
endmodule

//--- dac_serial_command_loader_bench.sv
// testbench: apb-driven host and converter end joined by the link
`timescale 1ns/10ps
module dac_serial_command_loader_bench import dscl_pkg::*;;
    logic        clk_in  = 1'b0;
    logic        nrst_in = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic [11:0] in_code, conv_code, in2, conv2, m_in, m_conv;
    logic        sd, upd, sd2, m_sd;
    logic [15:0] w;
    int          mismatches = 0;
    int          checks     = 0;
    int          upds       = 0;
    int          exp_upds   = 0;
    logic [15:0] corner [7] = '{16'h1FFE, 16'hE000, 16'h3000, 16'hC000, 16'h6FFE, 16'h8AAA, 16'h0000};
    dscl_if lk ();
    dscl_if lk2 ();
    dscl_host u_dscl_host (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .link(lk.host));
    dscl_dev u_dscl_dev (.clk_in(clk_in), .nrst_in(nrst_in), .link(lk.dev), .input_code_out(in_code),
        .conv_code_out(conv_code), .shutdown_out(sd), .update_out(upd));
    // second converter end, driven by hand with deliberately bad framing
    dscl_dev u_dscl_dev_fault (.clk_in(clk_in), .nrst_in(nrst_in), .link(lk2.dev), .input_code_out(in2),
        .conv_code_out(conv2), .shutdown_out(sd2), .update_out());
    dscl_link_chk u_dscl_link_chk (.clk_in(clk_in), .nrst_in(nrst_in), .select_n(lk.select_n),
        .shift_clock(lk.shift_clock), .serial_in(lk.serial_in));
    always #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (upd === 1'b1) upds++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; waits as long as pready stays low
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask
    // expected register effect of one command word
    function automatic void model(input logic [15:0] x);
        if (x[15:13] != 3'b011) exp_upds++;
        case (x[14:13])
            2'b00: begin
                m_in   = x[12:1];
                m_conv = x[12:1];
                m_sd   = 1'b0;
            end
            2'b01: m_in = x[12:1];
            2'b10: begin
                m_conv = m_in;
                m_sd   = 1'b0;
            end
            default: if (x[15]) m_sd = 1'b1;
        endcase
    endfunction
    task automatic send(input logic [15:0] x);
        apb(1'b1, REG_DATA, {16'h0, x});
        apb(1'b0, REG_DATA, 32'h0);
        chk(rd, {16'h0, x});
        apb(1'b1, REG_CTRL, 32'h1);
        do apb(1'b0, REG_STAT, 32'h0); while (rd[STAT_BUSY] !== 1'b0);
        repeat (12) @(posedge clk_in);
        model(x);
        chk({7'h0, sd, conv_code, in_code}, {7'h0, m_sd, m_conv, m_in});
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_in);
        mismatches++;
        wrap_up();
    end
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        lk2.select_n    = 1'b1;
        lk2.shift_clock = 1'b0;
        lk2.serial_in   = 1'b0;
        m_in   = 12'h000;
        m_conv = 12'h000;
        m_sd   = 1'b0;
        void'($urandom(32'hD8BB1344));
        repeat (5) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        chk({7'h0, sd, conv_code, in_code}, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk({31'h0, err}, 32'h1);
        // corners first: full scale, shutdown, load while asleep, recall, nop
        foreach (corner[i]) send(corner[i]);
        for (int i = 0; i < 40; i++) begin
            // sub bit left random: the host must clear it on the wire
            w = 16'($urandom);
            send(w);
        end
        chk(upds, exp_upds);
        // edges while deselected must not reach the shift register
        repeat (16) begin
            lk2.serial_in   <= 1'b1;
            lk2.shift_clock <= 1'b1;
            repeat (10) @(posedge clk_in);
            lk2.shift_clock <= 1'b0;
            lk2.serial_in   <= 1'b0;
            repeat (10) @(posedge clk_in);
        end
        lk2.select_n <= 1'b0;
        repeat (20) @(posedge clk_in);
        lk2.select_n <= 1'b1;
        repeat (12) @(posedge clk_in);
        chk({7'h0, sd2, conv2, in2}, 32'h0);
        wrap_up();
    end
endmodule
